//--- ias_pkg.sv
package ias_pkg;
  localparam logic [7:0] IAS_OFF_CTRL = 8'h00;
  localparam logic [7:0] IAS_OFF_BUF = 8'h04;
  localparam logic [7:0] IAS_OFF_STAT = 8'h08;
  localparam logic [7:0] IAS_OFF_MASK = 8'h0c;
  localparam logic [7:0] IAS_OFF_RATE = 8'h10;
  localparam int IAS_CTRL_ACK_GO = 0;
  localparam int IAS_CTRL_STOP_GO = 1;
  localparam int IAS_CTRL_ACK_VAL = 2;
  localparam int IAS_CTRL_HOLD = 3;
  localparam int IAS_ST_COLL = 0;
  localparam int IAS_ST_STOP = 1;
  localparam int IAS_ST_IRQ = 2;
  localparam int IAS_ST_W = 3;
  localparam logic [7:0] IAS_RATE_RESET = 8'h09;
  localparam logic [3:0] IAS_CTRL_RESET = 4'h0;
  localparam logic [2:0] IAS_ST_RESET = 3'h0;
  localparam logic [7:0] IAS_BUF_RESET = 8'h00;
  typedef enum logic [2:0] {
    IAS_IDLE,
    IAS_ACK_LOW,
    IAS_ACK_WAIT_HI,
    IAS_ACK_HIGH,
    IAS_STOP_SDA,
    IAS_STOP_COUNT,
    IAS_STOP_SCLHI,
    IAS_STOP_DONE
  } ias_state_t;
endpackage

//--- ias_rate_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ias_rate_if;
  logic run;
  logic reload;
  logic [7:0] period;
  logic expire;
  modport ctl (output run, output reload, output period, input expire);
  modport gen (input run, input reload, input period, output expire);
endinterface
`default_nettype wire

//--- ias_rate_gen.sv
`timescale 1ns/1ns
`default_nettype none
// counts period+1 cycles per rollover; stopped counter holds the reload value
module ias_rate_gen
  import ias_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  ias_rate_if.gen rif
);
  logic [7:0] cnt_q;
  wire at_zero = (cnt_q == 8'h00);
  always_ff @(posedge clock)
  begin
    if (rst || !rif.run || rif.reload || at_zero)
      cnt_q <= rst ? IAS_RATE_RESET : rif.period;
    else
      cnt_q <= cnt_q - 8'h01;
  end
  assign rif.expire = rif.run && !rif.reload && at_zero;
endmodule
`default_nettype wire

//--- ias_seq.sv
// Notes on behaviour
// - ack start pulls SCL low, presents ack bit
// - one rollover, then release SCL
// - SCL high seen, one rollover, SCL low
// - ack end clears go bit, goes idle
// - buffer write during ack sets collision, ignored
// - hold SCL low after ninth falling edge
// - stop start drives SDA low
// - SDA low seen, reload generator, count down
// - expiry releases SCL, SDA one rollover after SCL high seen
// - SDA high with SCL high sets stop flag
// - one rollover later clear go, set irq
// - buffer write during stop sets collision, ignored
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
module ias_seq
  import ias_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq
);
  ias_rate_if rif();
  ias_rate_gen u_rate (.clock(clock), .rst(rst), .rif(rif));

  logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;
  logic ack_go_q, stop_go_q, ack_val_q, hold_q;
  logic [7:0] buf_q, rate_q;
  logic [IAS_ST_W-1:0] stat_q, mask_q;
  ias_state_t st_q, st_d;
  logic scl_low_q, sda_low_q, run_q, reload_q;
  logic scl_low_d, sda_low_d, run_d, reload_d;
  logic pready_q, pslverr_q, irq_q;
  logic [31:0] prdata_q;
  logic stop_ev, done_ev, ack_done;

  // link pins pass two flops before any use
  always_ff @(posedge clock)
  begin
    scl_m_q <= scl_in;
    scl_s_q <= scl_m_q;
    sda_m_q <= sda_in;
    sda_s_q <= sda_m_q;
  end

  wire acc = psel && penable && !pready_q;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_ctrl = paddr == IAS_OFF_CTRL;
  wire hit_buf = paddr == IAS_OFF_BUF;
  wire hit_stat = paddr == IAS_OFF_STAT;
  wire hit_mask = paddr == IAS_OFF_MASK;
  wire hit_rate = paddr == IAS_OFF_RATE;
  wire mapped = hit_ctrl || hit_buf || hit_stat || hit_mask || hit_rate;
  wire busy = st_q != IAS_IDLE;
  wire buf_wr = wr && hit_buf;
  wire collide = buf_wr && (busy || ack_go_q || stop_go_q);
  wire [IAS_ST_W-1:0] set_v = {done_ev, stop_ev, collide};
  wire [IAS_ST_W-1:0] clr_v = (wr && hit_stat) ? pwdata[IAS_ST_W-1:0] : '0;
  wire [31:0] rd_mux =
    hit_ctrl ? {28'h0, hold_q, ack_val_q, stop_go_q, ack_go_q} :
    hit_buf ? {24'h0, buf_q} :
    hit_stat ? {29'h0, stat_q} :
    hit_mask ? {29'h0, mask_q} :
    hit_rate ? {24'h0, rate_q} : 32'h0;

  assign rif.run = run_q;
  assign rif.reload = reload_q;
  assign rif.period = rate_q;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= acc;
      pslverr_q <= acc && !mapped;
      prdata_q <= rd ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ack_val_q <= 1'b0;
      hold_q <= 1'b0;
      rate_q <= IAS_RATE_RESET;
      mask_q <= IAS_ST_RESET;
      buf_q <= IAS_BUF_RESET;
    end
    else
    begin
      if (wr && hit_ctrl)
      begin
        ack_val_q <= pwdata[IAS_CTRL_ACK_VAL];
        hold_q <= pwdata[IAS_CTRL_HOLD];
      end
      if (wr && hit_rate)
        rate_q <= pwdata[7:0];
      if (wr && hit_mask)
        mask_q <= pwdata[IAS_ST_W-1:0];
      if (buf_wr && !collide)
        buf_q <= pwdata[7:0];
    end
  end

  // a hardware set wins over a same-cycle write-one clear
  genvar gi;
  generate
    for (gi = 0; gi < IAS_ST_W; gi++)
    begin : g_stat
      always_ff @(posedge clock)
      begin
        if (rst)
          stat_q[gi] <= 1'b0;
        else if (set_v[gi])
          stat_q[gi] <= 1'b1;
        else if (clr_v[gi])
          stat_q[gi] <= 1'b0;
      end
    end
  endgenerate

  wire ctrl_wr = wr && hit_ctrl && !busy;
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ack_go_q <= 1'b0;
      stop_go_q <= 1'b0;
    end
    else
    begin
      if (ack_done)
        ack_go_q <= 1'b0;
      else if (ctrl_wr && pwdata[IAS_CTRL_ACK_GO] && !stop_go_q)
        ack_go_q <= 1'b1;
      if (done_ev)
        stop_go_q <= 1'b0;
      else if (ctrl_wr && pwdata[IAS_CTRL_STOP_GO] && !ack_go_q && !pwdata[IAS_CTRL_ACK_GO])
        stop_go_q <= 1'b1;
    end
  end

  always_comb
  begin
    st_d = st_q;
    scl_low_d = scl_low_q;
    sda_low_d = sda_low_q;
    run_d = run_q;
    reload_d = 1'b0;
    stop_ev = 1'b0;
    done_ev = 1'b0;
    ack_done = 1'b0;
    case (st_q)
      IAS_IDLE:
      begin
        run_d = 1'b0;
        // scl stays low after the ninth falling edge while software holds it
        scl_low_d = hold_q;
        sda_low_d = 1'b0;
        if (ack_go_q)
        begin
          st_d = IAS_ACK_LOW;
          scl_low_d = 1'b1;
          sda_low_d = !ack_val_q;
          run_d = 1'b1;
          reload_d = 1'b1;
        end
        else if (stop_go_q)
        begin
          st_d = IAS_STOP_SDA;
          scl_low_d = 1'b1;
          sda_low_d = 1'b1;
        end
      end
      IAS_ACK_LOW:
        if (rif.expire)
        begin
          scl_low_d = 1'b0;
          run_d = 1'b0;
          st_d = IAS_ACK_WAIT_HI;
        end
      IAS_ACK_WAIT_HI:
        if (scl_s_q)
        begin
          run_d = 1'b1;
          reload_d = 1'b1;
          st_d = IAS_ACK_HIGH;
        end
      IAS_ACK_HIGH:
        if (rif.expire)
        begin
          scl_low_d = 1'b1;
          sda_low_d = 1'b0;
          run_d = 1'b0;
          ack_done = 1'b1;
          st_d = IAS_IDLE;
        end
      IAS_STOP_SDA:
        if (!sda_s_q)
        begin
          run_d = 1'b1;
          reload_d = 1'b1;
          st_d = IAS_STOP_COUNT;
        end
      IAS_STOP_COUNT:
        if (rif.expire)
        begin
          scl_low_d = 1'b0;
          run_d = 1'b0;
          st_d = IAS_STOP_SCLHI;
        end
      IAS_STOP_SCLHI:
        if (!run_q && scl_s_q)
        begin
          run_d = 1'b1;
          reload_d = 1'b1;
        end
        else if (rif.expire)
        begin
          sda_low_d = 1'b0;
          run_d = 1'b0;
          st_d = IAS_STOP_DONE;
        end
      IAS_STOP_DONE:
        if (!run_q && sda_s_q && scl_s_q)
        begin
          stop_ev = 1'b1;
          run_d = 1'b1;
          reload_d = 1'b1;
        end
        else if (rif.expire)
        begin
          done_ev = 1'b1;
          run_d = 1'b0;
          st_d = IAS_IDLE;
        end
      default:
        st_d = IAS_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_q <= IAS_IDLE;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      run_q <= 1'b0;
      reload_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
      run_q <= run_d;
      reload_q <= reload_d;
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_low_q;
  assign sda_oe = sda_low_q;
  assign irq = irq_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  a_ack_release: assert property (@(posedge clock) disable iff (rst)
    st_q == IAS_ACK_LOW && rif.expire |=> !scl_oe && st_q == IAS_ACK_WAIT_HI)
    else $error("scl not released after ack low period");
  a_ack_start: assert property (@(posedge clock) disable iff (rst)
    st_q == IAS_IDLE && ack_go_q |=> scl_oe && sda_oe == !ack_val_q)
    else $error("ack start did not present bit");
  a_ack_wait: assert property (@(posedge clock) disable iff (rst)
    st_q == IAS_ACK_WAIT_HI && !scl_s_q |=> st_q == IAS_ACK_WAIT_HI && !run_q)
    else $error("ack count started while scl low");
  a_ack_rise: assert property (@(posedge clock) disable iff (rst)
    st_q == IAS_ACK_WAIT_HI && scl_s_q |=> st_q == IAS_ACK_HIGH && run_q && !scl_oe)
    else $error("ack high count not started");
  a_ack_end: assert property (@(posedge clock) disable iff (rst)
    st_q == IAS_ACK_HIGH && rif.expire |=> !ack_go_q && scl_oe && st_q == IAS_IDLE && !run_q)
    else $error("ack end not clean");
  a_coll_set: assert property (@(posedge clock) disable iff (rst)
    buf_wr && busy |=> stat_q[IAS_ST_COLL] && $stable(buf_q))
    else $error("collision not flagged");
  a_stop_sda: assert property (@(posedge clock) disable iff (rst)
    st_q == IAS_IDLE && stop_go_q && !ack_go_q |=> sda_oe && scl_oe)
    else $error("stop did not pull sda low");
  a_stop_count: assert property (@(posedge clock) disable iff (rst)
    st_q == IAS_STOP_SDA && !sda_s_q |=> st_q == IAS_STOP_COUNT && run_q && sda_oe)
    else $error("stop count not started");
  a_stop_scl: assert property (@(posedge clock) disable iff (rst)
    st_q == IAS_STOP_COUNT && rif.expire |=> !scl_oe && sda_oe && st_q == IAS_STOP_SCLHI)
    else $error("stop did not release scl first");
  a_stop_release: assert property (@(posedge clock) disable iff (rst)
    st_q == IAS_STOP_SCLHI && rif.expire |=> !sda_oe && !scl_oe && st_q == IAS_STOP_DONE)
    else $error("stop did not release sda");
  a_stop_flag: assert property (@(posedge clock) disable iff (rst)
    stop_ev |=> stat_q[IAS_ST_STOP])
    else $error("stop flag not set");
  a_stop_done: assert property (@(posedge clock) disable iff (rst)
    done_ev |=> !stop_go_q && stat_q[IAS_ST_IRQ] && st_q == IAS_IDLE)
    else $error("stop end not clean");
  a_coll_stop: assert property (@(posedge clock) disable iff (rst)
    buf_wr && stop_go_q |=> stat_q[IAS_ST_COLL] && $stable(buf_q))
    else $error("collision during stop not flagged");
  a_coll_keep: assert property (@(posedge clock) disable iff (rst)
    stat_q[IAS_ST_COLL] && !(wr && hit_stat && pwdata[IAS_ST_COLL]) |=> stat_q[IAS_ST_COLL])
    else $error("collision flag lost");
  a_hold_low: assert property (@(posedge clock) disable iff (rst)
    st_q == IAS_IDLE && !ack_go_q && !stop_go_q && hold_q |=> scl_oe)
    else $error("scl not held low after byte");
endmodule
`default_nettype wire

//--- ias_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
// open-drain bus with pull-ups; a slow slave may stretch scl after the master lets go
module ias_bus_model
(
  input wire logic clock,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic [7:0] stretch,
  output logic scl_in,
  output logic sda_in
);
  logic [7:0] hold_q = 8'h00;
  logic oe_q = 1'b0;
  always_ff @(posedge clock)
  begin
    oe_q <= scl_oe;
    if (oe_q && !scl_oe)
      hold_q <= stretch;
    else if (hold_q != 8'h00)
      hold_q <= hold_q - 8'h01;
  end
  // the release cycle is covered too, so no one-cycle high glitch leaks through
  assign scl_in = !scl_oe && hold_q == 8'h00 && !(oe_q && stretch != 8'h00);
  assign sda_in = !sda_oe;
endmodule
`default_nettype wire

//--- ias_seq_test.sv
`timescale 1ns/1ns
`default_nettype none
module ias_seq_test import ias_pkg::*;;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] stretch = 8'h00;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, irq;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int t0, t1, t2;
  ias_seq DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq(irq));
  ias_bus_model bus (.clock(clock), .scl_oe(scl_oe), .sda_oe(sda_oe), .stretch(stretch),
    .scl_in(scl_in), .sda_in(sda_in));
  always #10 clock = ~clock;
  task complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ceiling well above the few hundred cycles the tests need
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      complete_run;
    end
  end
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
    begin
      @(posedge clock);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("pready", n < 20, 32'h1);
  endtask
  task wait_lvl(input int sel, input logic v);
    int n;
    n = 0;
    while ((sel == 0 ? scl_oe : sel == 1 ? sda_oe : irq) !== v && n < 300)
    begin
      @(posedge clock);
      n++;
    end
    check("level wait", n < 300, 32'h1);
  endtask
  task t_reset;
    check("idle pins", {scl_oe, sda_oe, irq}, 32'h0);
    check("drive levels", {scl_out, sda_out}, 32'h0);
    apb(1'b0, IAS_OFF_RATE, 32'h0);
    check("rate", rd, IAS_RATE_RESET);
    check("mapped ok", err, 32'h0);
    apb(1'b0, IAS_OFF_CTRL, 32'h0);
    check("ctrl", rd, IAS_CTRL_RESET);
    apb(1'b0, IAS_OFF_STAT, 32'h0);
    check("stat", rd, IAS_ST_RESET);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped", err, 32'h1);
    apb(1'b1, IAS_OFF_BUF, 32'h33);
    apb(1'b0, IAS_OFF_BUF, 32'h0);
    check("buf", rd, 32'h33);
    $display("test reset done");
  endtask
  task t_ack(input logic v, input logic [7:0] st, input logic coll);
    stretch <= st;
    apb(1'b1, IAS_OFF_CTRL, {29'h0, v, 2'b00});
    apb(1'b1, IAS_OFF_CTRL, {29'h0, v, 2'b01});
    t0 = cyc;
    repeat (3) @(posedge clock);
    check("ack scl", scl_oe, 32'h1);
    check("ack sda", sda_oe, {31'h0, !v});
    wait_lvl(0, 1'b0);
    t1 = cyc;
    check("low phase", t1 - t0 >= 11 && t1 - t0 <= 15, 32'h1);
    if (coll)
    begin
      apb(1'b1, IAS_OFF_BUF, 32'ha5);
      apb(1'b1, IAS_OFF_CTRL, {29'h0, v, 2'b10});
    end
    wait_lvl(0, 1'b1);
    t2 = cyc;
    check("high phase", t2 - t1 >= st + 11 && t2 - t1 <= st + 17, 32'h1);
    apb(1'b0, IAS_OFF_CTRL, 32'h0);
    check("ack go", rd[IAS_CTRL_ACK_GO], 32'h0);
    check("ack stop refused", rd[IAS_CTRL_STOP_GO], 32'h0);
    apb(1'b0, IAS_OFF_BUF, 32'h0);
    check("buf kept", rd, 32'h33);
    apb(1'b0, IAS_OFF_STAT, 32'h0);
    check("ack collision", rd[IAS_ST_COLL], {31'h0, coll});
    apb(1'b1, IAS_OFF_STAT, 32'h1);
    $display("test ack done");
  endtask
  task t_stop;
    int n;
    stretch <= 8'h00;
    apb(1'b1, IAS_OFF_CTRL, 32'h2);
    wait_lvl(1, 1'b1);
    check("scl held", scl_oe, 32'h1);
    apb(1'b1, IAS_OFF_BUF, 32'h77);
    wait_lvl(0, 1'b0);
    t1 = cyc;
    wait_lvl(1, 1'b0);
    t2 = cyc;
    check("sda release", t2 - t1 >= 11 && t2 - t1 <= 17, 32'h1);
    n = 0;
    rd = 32'h2;
    while (rd[IAS_CTRL_STOP_GO] !== 1'b0 && n < 20)
    begin
      apb(1'b0, IAS_OFF_CTRL, 32'h0);
      n++;
    end
    check("stop go", rd[IAS_CTRL_STOP_GO], 32'h0);
    apb(1'b0, IAS_OFF_STAT, 32'h0);
    check("stop stat", rd, 32'h7);
    check("irq masked", irq, 32'h0);
    apb(1'b0, IAS_OFF_BUF, 32'h0);
    check("buf kept", rd, 32'h33);
    apb(1'b1, IAS_OFF_BUF, 32'h44);
    apb(1'b0, IAS_OFF_STAT, 32'h0);
    check("collision sticky", rd[IAS_ST_COLL], 32'h1);
    apb(1'b1, IAS_OFF_MASK, 32'h4);
    repeat (2) @(posedge clock);
    check("irq on", irq, 32'h1);
    apb(1'b1, IAS_OFF_STAT, 32'h7);
    repeat (2) @(posedge clock);
    check("irq off", irq, 32'h0);
    apb(1'b0, IAS_OFF_STAT, 32'h0);
    check("stat clear", rd, 32'h0);
    $display("test stop done");
  endtask
  task t_hold;
    check("released", scl_oe, 32'h0);
    apb(1'b1, IAS_OFF_CTRL, 32'h8);
    repeat (3) @(posedge clock);
    check("hold scl", scl_oe, 32'h1);
    $display("test hold done");
  endtask
  initial
  begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_ack(1'b0, 8'h00, 1'b1);
    t_ack(1'b1, 8'd40, 1'b0);
    t_stop;
    t_hold;
    complete_run;
  end
endmodule
`default_nettype wire
